// File: nau_pkg.sv
package nau_pkg;
  localparam int NAU_ACC_W = 4;
  localparam int NAU_PTR_W = 7;
  localparam int NAU_ROW_W = 3;
  localparam int NAU_DIG_W = 4;
  localparam int NAU_IP_W = 11;
  localparam int NAU_OP_W = 8;

  localparam logic [7:0] NAU_OP_SUM_CARRY = 8'h30;
  localparam logic [7:0] NAU_OP_ADD = 8'h31;
  localparam logic [7:0] NAU_OP_ADD_TEN = 8'h4A;
  localparam logic [3:0] NAU_OP_IMM_HI = 4'h5;
  localparam logic [7:0] NAU_OP_INV_SUM = 8'h10;
  localparam logic [7:0] NAU_OP_CLEAR_ACC = 8'h00;
  localparam logic [7:0] NAU_OP_COMPLEMENT = 8'h40;
  localparam logic [7:0] NAU_OP_XOR = 8'h02;
  localparam logic [7:0] NAU_OP_CARRY_CLEAR = 8'h32;
  localparam logic [7:0] NAU_OP_CARRY_SET = 8'h22;

  localparam logic [3:0] NAU_TEN = 4'hA;
  localparam logic [3:0] NAU_ACC_RST = 4'h0;
  localparam logic NAU_CARRY_RST = 1'b0;
  localparam logic [6:0] NAU_PTR_RST = 7'h00;
  localparam logic [10:0] NAU_IP_RST = 11'h000;
  localparam logic [10:0] NAU_IP_STEP = 11'h001;

  typedef enum logic [3:0] {
    NAU_SEL_NONE = 4'h0,
    NAU_SEL_SUM_CARRY = 4'h1,
    NAU_SEL_ADD = 4'h2,
    NAU_SEL_ADD_TEN = 4'h3,
    NAU_SEL_IMM = 4'h4,
    NAU_SEL_INV_SUM = 4'h5,
    NAU_SEL_CLEAR_ACC = 4'h6,
    NAU_SEL_COMPLEMENT = 4'h7,
    NAU_SEL_XOR = 4'h8,
    NAU_SEL_CARRY_CLEAR = 4'h9,
    NAU_SEL_CARRY_SET = 4'hA
  } nau_sel_e;
endpackage

// File: nau_alu_if.sv
`timescale 1ns/10ps
interface nau_alu_if;
  import nau_pkg::*;
  nau_sel_e sel;
  logic [NAU_ACC_W-1:0] acc;
  logic carry;
  logic [NAU_ACC_W-1:0] mem;
  logic [NAU_ACC_W-1:0] imm;
  logic [NAU_ACC_W-1:0] result;
  logic carry_out;
  logic acc_we;
  logic carry_we;
  logic skip;

  modport core (output sel, acc, carry, mem, imm, input result, carry_out, acc_we, carry_we, skip);
  modport alu (input sel, acc, carry, mem, imm, output result, carry_out, acc_we, carry_we, skip);
endinterface // nau_alu_if

// File: nau_alu.sv
`timescale 1ns/10ps
module nau_alu (
  nau_alu_if.alu a
);
  import nau_pkg::*;

  logic [NAU_ACC_W-1:0] op_x;
  logic [NAU_ACC_W-1:0] op_y;
  logic cin;
  logic [NAU_ACC_W:0] sum;

  always_comb begin
    op_x = a.acc;
    op_y = a.mem;
    cin = 1'b0;
    case (a.sel)
      NAU_SEL_SUM_CARRY: cin = a.carry;
      NAU_SEL_ADD_TEN: op_y = NAU_TEN;
      NAU_SEL_IMM: op_y = a.imm;
      NAU_SEL_INV_SUM: begin
        op_x = ~a.acc;
        cin = a.carry;
      end
      default: ;
    endcase
  end

  assign sum = {1'b0, op_x} + {1'b0, op_y} + {{NAU_ACC_W{1'b0}}, cin};

  always_comb begin
    a.result = sum[NAU_ACC_W-1:0];
    a.carry_out = sum[NAU_ACC_W];
    a.acc_we = 1'b1;
    a.carry_we = 1'b0;
    a.skip = 1'b0;
    case (a.sel)
      NAU_SEL_SUM_CARRY: begin
        a.carry_we = 1'b1;
        a.skip = sum[NAU_ACC_W];
      end
      NAU_SEL_ADD: ;
      NAU_SEL_ADD_TEN: ;
      NAU_SEL_IMM: a.skip = sum[NAU_ACC_W] && (a.imm != 4'h0);
      NAU_SEL_INV_SUM: begin
        a.carry_we = 1'b1;
        a.skip = sum[NAU_ACC_W];
      end
      NAU_SEL_CLEAR_ACC: a.result = NAU_ACC_RST;
      NAU_SEL_COMPLEMENT: a.result = ~a.acc;
      NAU_SEL_XOR: a.result = a.acc ^ a.mem;
      NAU_SEL_CARRY_CLEAR: begin
        a.acc_we = 1'b0;
        a.carry_we = 1'b1;
        a.carry_out = 1'b0;
      end
      NAU_SEL_CARRY_SET: begin
        a.acc_we = 1'b0;
        a.carry_we = 1'b1;
        a.carry_out = 1'b1;
      end
      default: a.acc_we = 1'b0;
    endcase
  end
endmodule // nau_alu

// File: nau_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - 30h: A+C+M, carry out, skip
// - 31h: A+M into A, no skip
// - 5yh: A+y, skip on carry unless y=0
// - 10h: ~A+M+C, carry out, skip
// - 40h: complement A, no skip
// - 02h: A xor M, no skip
// - One-bit carry; 32h clears, 22h sets
// - Four-bit A and pointed RAM operand
// - Seven-bit pointer: row 3, digit 4
// - Eleven-bit instruction pointer
// - Immediate is opcode low nibble
module nau_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic [nau_pkg::NAU_OP_W-1:0] opcode,
  input wire logic [nau_pkg::NAU_ACC_W-1:0] ram_rdata,
  input wire logic ptr_load,
  input wire logic [nau_pkg::NAU_PTR_W-1:0] ptr_value,
  input wire logic ip_load,
  input wire logic [nau_pkg::NAU_IP_W-1:0] ip_value,
  output logic [nau_pkg::NAU_ROW_W-1:0] row_select_bits,
  output logic [nau_pkg::NAU_DIG_W-1:0] digit_select_bits,
  output logic [nau_pkg::NAU_IP_W-1:0] instr_pointer,
  output logic [nau_pkg::NAU_ACC_W-1:0] acc,
  output logic carry,
  output logic skip_req
);
  import nau_pkg::*;

  logic [NAU_ACC_W-1:0] acc_q;
  logic [NAU_ACC_W-1:0] acc_d;
  logic carry_q;
  logic carry_d;
  logic [NAU_PTR_W-1:0] ptr_q;
  logic [NAU_IP_W-1:0] ip_q;
  logic skip_q;
  logic skip_d;
  wire execute;
  wire is_imm;
  nau_sel_e sel;

  nau_alu_if alu_bus();

  nau_alu u_alu (
    .a(alu_bus.alu)
  );

  assign execute = op_valid && !skip_q;
  assign is_imm = (opcode[7:4] == NAU_OP_IMM_HI);

  assign sel = !execute ? NAU_SEL_NONE :
               is_imm ? NAU_SEL_IMM :
               (opcode == NAU_OP_SUM_CARRY) ? NAU_SEL_SUM_CARRY :
               (opcode == NAU_OP_ADD) ? NAU_SEL_ADD :
               (opcode == NAU_OP_ADD_TEN) ? NAU_SEL_ADD_TEN :
               (opcode == NAU_OP_INV_SUM) ? NAU_SEL_INV_SUM :
               (opcode == NAU_OP_CLEAR_ACC) ? NAU_SEL_CLEAR_ACC :
               (opcode == NAU_OP_COMPLEMENT) ? NAU_SEL_COMPLEMENT :
               (opcode == NAU_OP_XOR) ? NAU_SEL_XOR :
               (opcode == NAU_OP_CARRY_CLEAR) ? NAU_SEL_CARRY_CLEAR :
               (opcode == NAU_OP_CARRY_SET) ? NAU_SEL_CARRY_SET : NAU_SEL_NONE;

  assign alu_bus.sel = sel;
  assign alu_bus.acc = acc_q;
  assign alu_bus.carry = carry_q;
  assign alu_bus.mem = ram_rdata;
  assign alu_bus.imm = opcode[3:0];

  assign acc_d = alu_bus.acc_we ? alu_bus.result : acc_q;
  assign carry_d = alu_bus.carry_we ? alu_bus.carry_out : carry_q;
  // Held until the squashed instruction arrives
  assign skip_d = op_valid ? (execute && alu_bus.skip) : skip_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_q <= NAU_ACC_RST;
      carry_q <= NAU_CARRY_RST;
      skip_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      carry_q <= carry_d;
      skip_q <= skip_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ptr_q <= NAU_PTR_RST;
    end else if (ptr_load) begin
      ptr_q <= ptr_value;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ip_q <= NAU_IP_RST;
    end else if (ip_load) begin
      ip_q <= ip_value;
    end else if (op_valid) begin
      ip_q <= ip_q + NAU_IP_STEP;
    end
  end

  assign row_select_bits = ptr_q[NAU_PTR_W-1:NAU_DIG_W];
  assign digit_select_bits = ptr_q[NAU_DIG_W-1:0];
  assign instr_pointer = ip_q;
  assign acc = acc_q;
  assign carry = carry_q;
  assign skip_req = skip_q;

  wire [NAU_ACC_W:0] chk_sum = {1'b0, acc_q} + {1'b0, ram_rdata} + {4'h0, carry_q};
  wire [NAU_ACC_W:0] chk_inv = {1'b0, ~acc_q} + {1'b0, ram_rdata} + {4'h0, carry_q};
  wire [NAU_ACC_W:0] chk_imm = {1'b0, acc_q} + {1'b0, opcode[3:0]};

  property p_sum_carry;
    @(posedge clk_sys) disable iff (rst)
    (execute && opcode == NAU_OP_SUM_CARRY) |=>
      acc_q == $past(chk_sum[3:0]) && carry_q == $past(chk_sum[4]) && skip_q == $past(chk_sum[4]);
  endproperty
  a_sum_carry: assert property (p_sum_carry) else $error("sum with carry wrong");

  property p_add;
    @(posedge clk_sys) disable iff (rst)
    (execute && opcode == NAU_OP_ADD) |=>
      acc_q == $past(acc_q) + $past(ram_rdata) && !skip_q && carry_q == $past(carry_q);
  endproperty
  a_add: assert property (p_add) else $error("plain add wrong");

  property p_imm;
    @(posedge clk_sys) disable iff (rst)
    (execute && is_imm) |=>
      acc_q == $past(chk_imm[3:0]) && carry_q == $past(carry_q) &&
      skip_q == ($past(chk_imm[4]) && $past(opcode[3:0]) != 4'h0);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate add wrong");

  property p_inv;
    @(posedge clk_sys) disable iff (rst)
    (execute && opcode == NAU_OP_INV_SUM) |=>
      acc_q == $past(chk_inv[3:0]) && carry_q == $past(chk_inv[4]) && skip_q == $past(chk_inv[4]);
  endproperty
  a_inv: assert property (p_inv) else $error("inverted sum wrong");

  property p_comp;
    @(posedge clk_sys) disable iff (rst)
    (execute && opcode == NAU_OP_COMPLEMENT) |=> acc_q == ~$past(acc_q) && !skip_q;
  endproperty
  a_comp: assert property (p_comp) else $error("complement wrong");

  property p_xor;
    @(posedge clk_sys) disable iff (rst)
    (execute && opcode == NAU_OP_XOR) |=> acc_q == ($past(acc_q) ^ $past(ram_rdata)) && !skip_q;
  endproperty
  a_xor: assert property (p_xor) else $error("xor wrong");

  property p_carry_ops;
    @(posedge clk_sys) disable iff (rst)
    (execute && (opcode == NAU_OP_CARRY_SET || opcode == NAU_OP_CARRY_CLEAR)) |=>
      carry_q == ($past(opcode) == NAU_OP_CARRY_SET) && acc_q == $past(acc_q) && !skip_q;
  endproperty
  a_carry_ops: assert property (p_carry_ops) else $error("carry set or clear wrong");

  property p_squash;
    @(posedge clk_sys) disable iff (rst)
    (skip_q && op_valid) |=> !skip_q && acc_q == $past(acc_q) && carry_q == $past(carry_q);
  endproperty
  a_squash: assert property (p_squash) else $error("skipped instruction executed");

  property p_ip_step;
    @(posedge clk_sys) disable iff (rst)
    (op_valid && !ip_load) |=> ip_q == $past(ip_q) + NAU_IP_STEP;
  endproperty
  a_ip_step: assert property (p_ip_step) else $error("instruction pointer step wrong");

  property p_ptr;
    @(posedge clk_sys) disable iff (rst)
    ptr_load |=> {row_select_bits, digit_select_bits} == $past(ptr_value);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load wrong");

  property p_add_ten;
    @(posedge clk_sys) disable iff (rst)
    (execute && opcode == NAU_OP_ADD_TEN) |=>
      acc_q == $past(acc_q) + NAU_TEN && carry_q == $past(carry_q) && !skip_q;
  endproperty
  a_add_ten: assert property (p_add_ten) else $error("add ten wrong");

  property p_clear_acc;
    @(posedge clk_sys) disable iff (rst)
    (execute && opcode == NAU_OP_CLEAR_ACC) |=>
      acc_q == NAU_ACC_RST && carry_q == $past(carry_q) && !skip_q;
  endproperty
  a_clear_acc: assert property (p_clear_acc) else $error("clear accumulator wrong");

  // Load must win over the increment
  property p_ip_load;
    @(posedge clk_sys) disable iff (rst)
    ip_load |=> instr_pointer == $past(ip_value);
  endproperty
  a_ip_load: assert property (p_ip_load) else $error("instruction pointer load wrong");

  property p_idle;
    @(posedge clk_sys) disable iff (rst)
    !op_valid |=> acc_q == $past(acc_q) && carry_q == $past(carry_q) && skip_q == $past(skip_q);
  endproperty
  a_idle: assert property (p_idle) else $error("state changed with no instruction");

  c_skip_sum: cover property (@(posedge clk_sys) disable iff (rst)
    execute && opcode == NAU_OP_SUM_CARRY ##1 skip_q ##[1:3] op_valid);
  c_imm_zero: cover property (@(posedge clk_sys) disable iff (rst) execute && opcode == 8'h50);
  c_inv_carry: cover property (@(posedge clk_sys) disable iff (rst)
    execute && opcode == NAU_OP_INV_SUM && chk_inv[4]);
  c_set_then_clear: cover property (@(posedge clk_sys) disable iff (rst)
    execute && opcode == NAU_OP_CARRY_SET ##[1:4] execute && opcode == NAU_OP_CARRY_CLEAR);
  c_squash_burst: cover property (@(posedge clk_sys) disable iff (rst)
    skip_q && op_valid ##1 execute);
endmodule // nau_top

// File: nau_ram_model.sv
`timescale 1ns/10ps
module nau_ram_model (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [3:0] wdata,
  input wire logic [2:0] row_select_bits,
  input wire logic [3:0] digit_select_bits,
  output logic [3:0] ram_rdata
);
  // Not cleared by reset, so unwritten cells read unknown
  logic [3:0] mem [128];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign ram_rdata = mem[{row_select_bits, digit_select_bits}];
endmodule // nau_ram_model

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [3:0] ram_rdata;
  logic ptr_load = 1'b0;
  logic [6:0] ptr_value = 7'h00;
  logic ip_load = 1'b0;
  logic [10:0] ip_value = 11'h000;
  logic we = 1'b0;
  logic [6:0] waddr = 7'h00;
  logic [3:0] wdata = 4'h0;
  logic [2:0] row_select_bits;
  logic [3:0] digit_select_bits;
  logic [10:0] instr_pointer;
  logic [3:0] acc;
  logic carry;
  logic skip_req;
  int n_mismatch = 0;
  int checks_done = 0;

  always #5 clk_sys = ~clk_sys;

  nau_top nau_top_i (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .opcode(opcode), .ram_rdata(ram_rdata),
    .ptr_load(ptr_load), .ptr_value(ptr_value), .ip_load(ip_load), .ip_value(ip_value),
    .row_select_bits(row_select_bits), .digit_select_bits(digit_select_bits),
    .instr_pointer(instr_pointer), .acc(acc), .carry(carry), .skip_req(skip_req));

  nau_ram_model nau_ram_model_i (.clk_sys(clk_sys), .we(we), .waddr(waddr), .wdata(wdata),
    .row_select_bits(row_select_bits), .digit_select_bits(digit_select_bits), .ram_rdata(ram_rdata));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Leaves one idle cycle after each instruction; sample once that edge has landed
  task automatic op(input logic [7:0] o);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    opcode <= o;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic ex(input logic [7:0] o, input logic [3:0] a, input logic c, input logic s);
    op(o);
    chk("acc", 11'(acc), 11'(a));
    chk("carry", 11'(carry), 11'(c));
    chk("skip_req", 11'(skip_req), 11'(s));
  endtask

  task automatic ld(input logic [3:0] v);
    op(8'h00);
    op({4'h5, v});
  endtask

  task automatic poke(input logic [6:0] a, input logic [3:0] d);
    @(posedge clk_sys);
    we <= 1'b1;
    waddr <= a;
    wdata <= d;
    @(posedge clk_sys);
    we <= 1'b0;
  endtask

  task automatic point(input logic [6:0] p);
    @(posedge clk_sys);
    ptr_load <= 1'b1;
    ptr_value <= p;
    @(posedge clk_sys);
    ptr_load <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    chk("acc", 11'(acc), 11'h000);
    chk("skip", 11'({carry, skip_req}), 11'h000);
    chk("ptr", 11'({row_select_bits, digit_select_bits}), 11'h000);
    chk("ip", instr_pointer, 11'h000);
  endtask

  task automatic t_ptr;
    poke(7'h35, 4'h1);
    poke(7'h12, 4'h4);
    point(7'h12);
    chk("row", 11'(row_select_bits), 11'h001);
    chk("digit", 11'(digit_select_bits), 11'h002);
    ld(4'h3);
    ex(8'h31, 4'h7, 1'b0, 1'b0);
    point(7'h35);
    chk("ptr", 11'({row_select_bits, digit_select_bits}), 11'h035);
  endtask

  task automatic t_asc;
    ld(4'hF);
    ex(8'h32, 4'hF, 1'b0, 1'b0);
    ex(8'h30, 4'h0, 1'b1, 1'b1);
    ex(8'h40, 4'h0, 1'b1, 1'b0);
    ex(8'h30, 4'h2, 1'b0, 1'b0);
  endtask

  task automatic t_add;
    ld(4'hF);
    ex(8'h22, 4'hF, 1'b1, 1'b0);
    ex(8'h31, 4'h0, 1'b1, 1'b0);
    ex(8'h4A, 4'hA, 1'b1, 1'b0);
    ex(8'h4A, 4'h4, 1'b1, 1'b0);
  endtask

  task automatic t_imm;
    logic [3:0] y;
    op(8'h32);
    for (int i = 0; i < 16; i++) begin
      y = 4'(i);
      ld(4'hF);
      ex({4'h5, y}, 4'hF + y, 1'b0, y != 4'h0);
      if (y != 4'h0) begin
        ex(8'h44, 4'hF + y, 1'b0, 1'b0);
      end
    end
  endtask

  task automatic t_inverted_sum_with_carry;
    ld(4'h5);
    op(8'h32);
    ex(8'h10, 4'hB, 1'b0, 1'b0);
    op(8'h22);
    ld(4'h0);
    ex(8'h10, 4'h1, 1'b1, 1'b1);
    ex(8'h44, 4'h1, 1'b1, 1'b0);
  endtask

  task automatic t_logic;
    ld(4'h6);
    op(8'h32);
    ex(8'h40, 4'h9, 1'b0, 1'b0);
    poke(7'h35, 4'h7);
    ex(8'h02, 4'hE, 1'b0, 1'b0);
    ex(8'h22, 4'hE, 1'b1, 1'b0);
    ex(8'h32, 4'hE, 1'b0, 1'b0);
  endtask

  task automatic t_ip;
    @(posedge clk_sys);
    ip_load <= 1'b1;
    ip_value <= 11'h123;
    op_valid <= 1'b1;
    opcode <= 8'h44;
    @(posedge clk_sys);
    ip_load <= 1'b0;
    op_valid <= 1'b0;
    #1;
    chk("ip", instr_pointer, 11'h123);
    @(posedge clk_sys);
    ip_load <= 1'b1;
    ip_value <= 11'h7FF;
    @(posedge clk_sys);
    ip_load <= 1'b0;
    #1;
    chk("ip", instr_pointer, 11'h7FF);
    op(8'h44);
    chk("ip", instr_pointer, 11'h000);
  endtask

  // Back-to-back instructions, with a squash in the middle
  task automatic t_burst;
    @(posedge clk_sys);
    op_valid <= 1'b1;
    opcode <= 8'h00;
    @(posedge clk_sys);
    opcode <= 8'h5F;
    @(posedge clk_sys);
    opcode <= 8'h51;
    @(posedge clk_sys);
    opcode <= 8'h5F;
    #1;
    chk("skip_req", 11'(skip_req), 11'h001);
    chk("acc", 11'(acc), 11'h000);
    @(posedge clk_sys);
    opcode <= 8'h53;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk("acc", 11'(acc), 11'h003);
    chk("skip_req", 11'(skip_req), 11'h000);
    chk("carry", 11'(carry), 11'h000);
    chk("ip", instr_pointer, 11'h005);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    t_reset();
    t_ptr();
    t_asc();
    t_add();
    t_imm();
    t_inverted_sum_with_carry();
    t_logic();
    t_ip();
    t_burst();
    end_of_test();
  end

  // Whole run is a few hundred cycles; this leaves ample margin
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule // testbench
